// ===== logic/tsr_pkg.sv
package tsr_pkg;
	localparam int FRAME_BITS       = 16;
	localparam int TEMP_BITS        = 13;
	localparam int HIZ_BITS         = 2;
	localparam logic [12:0] TEMP_RESET = 13'h0000;
	localparam int CLK_MHZ          = 125;
	localparam int CONV_TIME_MS     = 320;
	localparam int CONV_PERIOD_MS   = 500;
	localparam int CONV_CYCLES      = CONV_TIME_MS * 1000 * CLK_MHZ;
	localparam int PERIOD_CYCLES    = CONV_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int CNT_W            = 32;
endpackage

// ===== logic/tsr_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for one pin
module tsr_sync (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic d_in,
	input  wire logic rst_val_in,
	output logic      q_out
);
	logic meta_reg;
	// First stage read only by the second
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta_reg <= rst_val_in; // Idle level of the pin, so no false edge
			q_out    <= rst_val_in;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule

// ===== logic/tsr_readout.sv
`timescale 1ns/1ps
// Serial readout and conversion control of the thermometer
// Pins are sampled by the system clock, not clocked by SCK
// SCK high and low must each last several clock periods
// Select and SCK edges act some two to three clocks late
// Converter is a timed stand-in; its value comes from a port
module tsr_readout #(
	parameter int CONV_CYCLES   = tsr_pkg::CONV_CYCLES,
	parameter int PERIOD_CYCLES = tsr_pkg::PERIOD_CYCLES
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        cs_b_in,
	input  wire logic        sck_in,
	input  wire logic [12:0] adc_temp_in,
	output logic             sdo_out,
	output logic             sdo_oe_out,
	output logic             conv_busy_out,
	output logic [12:0]      temp_out
);
	typedef enum logic [1:0] {
		TSR_IDLE = 2'b01,
		TSR_CONV = 2'b10
	} tsr_conv_type;

	typedef struct packed {
		// Converter
		tsr_conv_type                         conv;
		logic [tsr_pkg::CNT_W-1:0]            cnt;
		logic [tsr_pkg::TEMP_BITS-1:0]        result;
		// Serial shifter
		logic [tsr_pkg::FRAME_BITS-1:0]       shift;
		logic [4:0]                           bit_cnt;
		logic                                 sdo;
		logic                                 oe;
		// Edge history of the synchronised pins
		logic                                 cs_d;
		logic                                 sck_d;
	} tsr_state_type;

	tsr_state_type s_reg;
	tsr_state_type s_next;
	logic          cs_s;
	logic          sck_s;
	logic          cs_fall;
	logic          cs_rise;
	logic          sck_fall;

	// Pins cross into the clock domain first
	tsr_sync u_cs (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.d_in       (cs_b_in),
		.rst_val_in (1'b1),
		.q_out      (cs_s)
	);
	tsr_sync u_sck (
		.clk_in     (clk_in),
		.rst_b_in   (rst_b_in),
		.d_in       (sck_in),
		.rst_val_in (1'b0),
		.q_out      (sck_s)
	);

	// Last counts of a conversion and of the free-running gap
	localparam logic [tsr_pkg::CNT_W-1:0] CONV_LAST = CONV_CYCLES - 1;
	localparam logic [tsr_pkg::CNT_W-1:0] GAP_LAST  = PERIOD_CYCLES - CONV_CYCLES - 1;
	// SDO is released once this many bits have gone out
	localparam logic [4:0] DRIVE_BITS = 5'(tsr_pkg::FRAME_BITS - tsr_pkg::HIZ_BITS);
	// Falling SCK edges beyond this count are ignored
	localparam logic [4:0] LAST_BIT   = 5'(tsr_pkg::FRAME_BITS);

	// True once a counter has reached its last value
	function automatic logic count_done(
		input logic [tsr_pkg::CNT_W-1:0] cnt,
		input logic [tsr_pkg::CNT_W-1:0] last
	);
		return cnt >= last;
	endfunction

	// Counter advance; a wide counter never wraps inside a period
	function automatic logic [tsr_pkg::CNT_W-1:0] count_step(
		input logic [tsr_pkg::CNT_W-1:0] cnt
	);
		return cnt + 1'b1;
	endfunction

	// Word loaded at select: temperature, a zero, two released bits
	function automatic logic [tsr_pkg::FRAME_BITS-1:0] frame_word(
		input logic [tsr_pkg::TEMP_BITS-1:0] temp
	);
		return {temp, 1'b0, 2'b00};
	endfunction

	// One place up, zero in behind; the bit on SDO sits at the top, the next just below
	function automatic logic [tsr_pkg::FRAME_BITS-1:0] shift_up(
		input logic [tsr_pkg::FRAME_BITS-1:0] word
	);
		return {word[tsr_pkg::FRAME_BITS-2:0], 1'b0};
	endfunction

	// Whether SDO is still driven after a given number of shifts
	function automatic logic still_driven(
		input logic [4:0] shifted
	);
		return shifted < DRIVE_BITS;
	endfunction

	// Counter limits decoded once, read by the converter timing
	logic conv_done;
	logic gap_done;
	assign conv_done = count_done(s_reg.cnt, CONV_LAST);
	assign gap_done  = count_done(s_reg.cnt, GAP_LAST);

	// Edge detection on synchronised copies
	// History resets to the idle levels, so reset gives no edge
	assign cs_fall  = s_reg.cs_d & ~cs_s;
	assign cs_rise  = ~s_reg.cs_d & cs_s;
	assign sck_fall = s_reg.sck_d & ~sck_s & ~cs_s;

	// Next-state logic
	always_comb begin
		s_next       = s_reg;
		s_next.cs_d  = cs_s;
		s_next.sck_d = sck_s;
		// Converter timing; both waits share one counter
		unique case (s_reg.conv)
			TSR_IDLE: begin
				// Free-running wait between conversions
				if (cs_s) begin
					if (gap_done) begin
						s_next.conv = TSR_CONV;
						s_next.cnt  = '0;
					end else begin
						s_next.cnt = count_step(s_reg.cnt);
					end
				end
			end
			TSR_CONV: begin
				if (conv_done) begin
					s_next.conv   = TSR_IDLE;
					s_next.cnt    = '0;
					s_next.result = adc_temp_in; // Stored only on completion
				end else begin
					s_next.cnt = count_step(s_reg.cnt);
				end
			end
			default: begin
				// Lost one-hot code; fall back to waiting
				s_next.conv = TSR_IDLE;
				s_next.cnt  = '0;
			end
		endcase

		// Serial interface; select edges take priority over SCK
		if (cs_fall) begin
			s_next.conv   = TSR_IDLE; // Abort, old result kept
			s_next.cnt    = '0;
			// A result finishing at this very edge is dropped with the abort
			s_next.result = s_reg.result;
			// Shifter takes the last finished result
			s_next.shift   = frame_word(s_reg.result);
			s_next.bit_cnt = 5'h00;
			s_next.sdo     = s_reg.result[tsr_pkg::TEMP_BITS-1]; // MSB first
			s_next.oe      = 1'b1;
		end else if (cs_rise) begin
			s_next.conv    = TSR_CONV; // Fresh conversion always
			s_next.cnt     = '0;
			// Interface back to its idle state
			s_next.shift   = '0;
			s_next.bit_cnt = 5'h00;
			s_next.oe      = 1'b0;
			s_next.sdo     = 1'b0;
		end else if (sck_fall && s_reg.bit_cnt < LAST_BIT) begin
			// Next bit after each of the first 16 falling SCK edges
			s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
			s_next.shift   = shift_up(s_reg.shift);
			s_next.sdo     = s_reg.shift[tsr_pkg::FRAME_BITS-2];
			// Undriven for the last two bits and beyond
			s_next.oe = still_driven(s_reg.bit_cnt + 1'b1);
		end

		// Held select keeps the converter parked
		if (!cs_s) begin
			s_next.conv = TSR_IDLE;
		end
	end

	// State register; reset starts a conversion
	// Edge history starts at each pin's idle level
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_reg.conv    <= TSR_CONV;
			s_reg.cnt     <= '0;
			s_reg.result  <= tsr_pkg::TEMP_RESET;
			s_reg.shift   <= '0;
			s_reg.bit_cnt <= 5'h00;
			s_reg.sdo     <= 1'b0;
			s_reg.oe      <= 1'b0;
			s_reg.cs_d    <= 1'b1;
			s_reg.sck_d   <= 1'b0; // SCK idles low
		end else begin
			s_reg <= s_next;
		end
	end

	// Serial data straight from the shifter flop
	assign sdo_out       = s_reg.sdo;

	// SDO undriven while deselected
	// Gated by the synchronised select so release is not a clock late
	assign sdo_oe_out    = s_reg.oe & ~cs_s;

	// Converter status and last finished result
	assign conv_busy_out = (s_reg.conv == TSR_CONV);
	assign temp_out      = s_reg.result;
endmodule

// ===== verif/tsr_chk.sv
`timescale 1ns/1ps
module tsr_chk #(
	parameter int CONV_CYCLES   = 50,
	parameter int PERIOD_CYCLES = 80
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        cs_b_in,
	input  wire logic        sck_in,
	input  wire logic [12:0] adc_temp_in,
	input  wire logic        sdo_out,
	input  wire logic        sdo_oe_out,
	input  wire logic        conv_busy_out,
	input  wire logic [12:0] temp_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	int busy_reg;
	int idle_reg;
	// Run lengths of a conversion and of the free-running gap
	always_ff @(posedge clk_in) begin
		busy_reg <= (conv_busy_out && rst_b_in) ? busy_reg + 1 : 0;
		idle_reg <= (conv_busy_out || !cs_b_in || !rst_b_in) ? 0 : idle_reg + 1;
	end
	a_oe_idle: assert property (cs_b_in [*5] |-> !sdo_oe_out)
		else $error("sdo driven while deselected");
	a_oe_on: assert property ($fell(cs_b_in) ##1 !cs_b_in [*6] |-> sdo_oe_out)
		else $error("sdo not driven after select");
	a_first_bit: assert property ($rose(sdo_oe_out) |-> sdo_out == temp_out[12])
		else $error("first bit is not the sign");
	a_no_conv: assert property (!cs_b_in [*6] |-> !conv_busy_out)
		else $error("conversion runs while selected");
	a_held_result: assert property (!cs_b_in [*6] |-> $stable(temp_out))
		else $error("result moved while selected");
	a_conv_go: assert property ($rose(cs_b_in) ##1 cs_b_in [*5] |-> conv_busy_out)
		else $error("no conversion after deselect");
	a_conv_len: assert property ($changed(temp_out) |->
		$past(busy_reg) inside {[CONV_CYCLES - 2:CONV_CYCLES + 2]})
		else $error("conversion length wrong");
	a_result_val: assert property ($changed(temp_out) |-> temp_out == $past(adc_temp_in))
		else $error("result differs from converter");
	a_gap_len: assert property (idle_reg <= PERIOD_CYCLES - CONV_CYCLES + 2)
		else $error("free-running gap too long");
endmodule
bind tsr_readout tsr_chk #(.CONV_CYCLES(CONV_CYCLES), .PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.*);

// ===== verif/tsr_master.sv
`timescale 1ns/1ps
module tsr_master (
	output logic      cs_b_out,
	output logic      sck_out,
	input  wire logic sdo_in,
	input  wire logic sdo_oe_in
);
	initial {cs_b_out, sck_out} = 2'b10;
	// One frame; SCK idles low and stands still between frames
	task automatic frame(output logic [15:0] d, output logic [15:0] oe);
		#0.25 cs_b_out = 1'b0; // Off the clock grid, so no race with sampling
		#125;
		for (int i = 15; i >= 0; i--) begin
			sck_out = 1'b1;
			d[i] = sdo_in;
			oe[i] = sdo_oe_in;
			#62.5 sck_out = 1'b0;
			#62.5;
		end
		cs_b_out = 1'b1; // Caller keeps CS high long enough
	endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clk_in, rst_b_in, cs_b, sck, sdo, oe, busy;
	logic [12:0] adc, temp;
	logic [15:0] d, e;
	int          fails, total_checks, cyc;
	tsr_readout #(.CONV_CYCLES(50), .PERIOD_CYCLES(80)) i_dut (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .cs_b_in(cs_b), .sck_in(sck), .adc_temp_in(adc),
		.sdo_out(sdo), .sdo_oe_out(oe), .conv_busy_out(busy), .temp_out(temp));
	tsr_master i_mst (.cs_b_out(cs_b), .sck_out(sck), .sdo_in(sdo), .sdo_oe_in(oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Read a frame; low two bits are not driven
	task automatic read_frame(input logic [12:0] t);
		i_mst.frame(d, e);
		chk(d & 16'hfffc, {t, 3'h0});
		chk(e, 16'hfffc);
	endtask
	task automatic wait_set(input int n, input logic [12:0] v);
		repeat (n) @(posedge clk_in);
		adc <= v;
	endtask
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Hang guard, well above the expected run
	always @(posedge clk_in) if (++cyc > 5000) begin
		fails++;
		tally_and_finish();
	end
	initial begin
		{rst_b_in, adc} = {1'b0, 13'h07d0};
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		chk({3'h0, temp}, 16'h0000);
		chk({15'h0000, busy}, 16'h0001);
		wait_set(60, 13'h07d0);
		chk({3'h0, temp}, {3'h0, 13'h07d0});
		read_frame(13'h07d0);
		chk({15'h0000, busy}, 16'h0000);
		wait_set(1, 13'h1c90);
		wait_set(60, 13'h1c90);
		chk({3'h0, temp}, {3'h0, 13'h1c90});
		wait_set(20, 13'h0190);
		read_frame(13'h1c90);
		chk({3'h0, temp}, {3'h0, 13'h1c90});
		wait_set(60, 13'h1e70);
		chk({3'h0, temp}, {3'h0, 13'h0190});
		wait_set(100, 13'h1e70);
		chk({3'h0, temp}, {3'h0, 13'h1e70});
		tally_and_finish();
	end
endmodule
